// [verilog/mbxr_pkg.sv]
// constants for the modbus slave exception responder
package mbxr_pkg;
   // register addresses of the display set-up group
   localparam logic [15:0] ADDR_TEMP_UNIT   = 16'h0081;
   localparam logic [15:0] ADDR_DEC_POINT   = 16'h009B;
   localparam logic [15:0] ADDR_MAINS_FREQ  = 16'h00A6;
   localparam logic [15:0] ADDR_LANGUAGE    = 16'h00C0;
   localparam logic [15:0] ADDR_RATIO2_EN   = 16'h00D0;
   // largest legal value of each register
   localparam logic [15:0] MAX_TEMP_UNIT    = 16'h0002;
   localparam logic [15:0] MAX_DEC_POINT    = 16'h0003;
   localparam logic [15:0] MAX_MAINS_FREQ   = 16'h0001;
   localparam logic [15:0] MAX_LANGUAGE     = 16'h0004;
   localparam logic [15:0] MAX_RATIO2_EN    = 16'h0001;
   // reset values
   localparam logic [15:0] RST_TEMP_UNIT    = 16'h0000;
   localparam logic [15:0] RST_DEC_POINT    = 16'h0000;
   localparam logic [15:0] RST_MAINS_FREQ   = 16'h0000;
   localparam logic [15:0] RST_LANGUAGE     = 16'h0000;
   localparam logic [15:0] RST_RATIO2_EN    = 16'h0000;
   // function codes
   localparam logic [7:0]  FC_READ_HOLD     = 8'h03;
   localparam logic [7:0]  FC_READ_INPUT    = 8'h04;
   localparam logic [7:0]  FC_WRITE_SINGLE  = 8'h06;
   localparam logic [7:0]  FC_WRITE_MULTI   = 8'h10;
   localparam logic [7:0]  FC_READ_FILE     = 8'h14;
   localparam logic [7:0]  FC_EXC_FLAG      = 8'h80;
   // exception codes
   localparam logic [7:0]  EXC_ILL_FUNC     = 8'h01;
   localparam logic [7:0]  EXC_ILL_ADDR     = 8'h02;
   localparam logic [7:0]  EXC_ILL_VALUE    = 8'h03;
   localparam logic [7:0]  EXC_DEV_FAIL     = 8'h04;
   localparam logic [7:0]  EXC_BUSY         = 8'h06;
   localparam logic [7:0]  EXC_NAK          = 8'h07;
   localparam logic [7:0]  EXC_BUF_OVF      = 8'h09;
   // sizes
   localparam int          NUM_REGS         = 5;
   localparam logic [7:0]  MAX_READ_COUNT   = 8'h05;
   localparam logic [7:0]  MAX_FILE_WORDS   = 8'h7D;
   localparam logic [2:0]  REG_NONE         = 3'h7;
   // response kinds
   typedef enum logic [1:0]
   {
      MBXR_RSP_NONE   = 2'b00,
      MBXR_RSP_NORMAL = 2'b01,
      MBXR_RSP_EXC    = 2'b10
   } mbxr_rsp_e;
endpackage : mbxr_pkg

// [verilog/mbxr_reg_bank.sv]
// display set-up register bank with range check
`timescale 1ns/100ps
`default_nettype none
module mbxr_reg_bank
   import mbxr_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // access
   input  wire logic [2:0]  sel_idx,
   input  wire logic        wr_en,
   input  wire logic [15:0] wr_data,
   // results
   output logic      [15:0] rd_data,
   output logic             val_ok,
   // direct views
   output logic      [15:0] temp_unit,
   output logic      [15:0] dec_point,
   output logic      [15:0] mains_freq,
   output logic      [15:0] language,
   output logic      [15:0] ratio2_en
);
   localparam logic [15:0] MAXV [NUM_REGS] = '{MAX_TEMP_UNIT, MAX_DEC_POINT,
      MAX_MAINS_FREQ, MAX_LANGUAGE, MAX_RATIO2_EN};
   localparam logic [15:0] RSTV [NUM_REGS] = '{RST_TEMP_UNIT, RST_DEC_POINT,
      RST_MAINS_FREQ, RST_LANGUAGE, RST_RATIO2_EN};

   logic [15:0] bank_r [NUM_REGS];

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++)
      begin : g_reg
         always_ff @(posedge ref_clk or posedge sys_rst)
         begin
            if (sys_rst)
               bank_r[g] <= RSTV[g];
            else if (wr_en && sel_idx == 3'(g) && wr_data <= MAXV[g])
               bank_r[g] <= wr_data;
         end
      end
   endgenerate

   always_comb
   begin
      rd_data = 16'h0000;
      val_ok  = 1'b0;
      if (sel_idx < 3'(NUM_REGS))
      begin
         rd_data = bank_r[sel_idx];
         val_ok  = (wr_data <= MAXV[sel_idx]);
      end
   end

   assign temp_unit  = bank_r[0];
   assign dec_point  = bank_r[1];
   assign mains_freq = bank_r[2];
   assign language   = bank_r[3];
   assign ratio2_en  = bank_r[4];
endmodule : mbxr_reg_bank
`default_nettype wire

// [verilog/mbxr_responder.sv]
// modbus slave query decision and exception encoding
`timescale 1ns/100ps
`default_nettype none
module mbxr_responder
   import mbxr_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // parsed query from the framing logic
   input  wire logic        qry_valid,
   input  wire logic        qry_comm_err,
   input  wire logic [7:0]  qry_slave_addr,
   input  wire logic [7:0]  qry_func,
   input  wire logic [15:0] qry_reg_addr,
   input  wire logic [15:0] qry_value,
   input  wire logic [7:0]  qry_file_words,
   // device condition
   input  wire logic        dev_fault,
   input  wire logic        dev_busy,
   input  wire logic        dev_nak,
   // response to the framing and crc logic
   output logic             rsp_valid,
   output logic             rsp_exception,
   output logic [7:0]       rsp_slave_addr,
   output logic [7:0]       rsp_func,
   output logic [7:0]       rsp_exc_code,
   output logic [15:0]      rsp_data,
   output logic             rsp_dropped,
   // display set-up values
   output logic [15:0]      temp_unit,
   output logic [15:0]      dec_point,
   output logic [15:0]      mains_freq,
   output logic [15:0]      language,
   output logic [15:0]      ratio2_en
);
   logic        rsp_valid_r;
   logic        rsp_exc_r;
   logic [7:0]  rsp_addr_r;
   logic [7:0]  rsp_func_r;
   logic [7:0]  rsp_code_r;
   logic [15:0] rsp_data_r;
   logic        drop_r;
   logic [2:0]  sel_idx;
   logic        is_write;
   logic        wr_en;
   logic [15:0] rd_data;
   logic        val_ok;
   mbxr_rsp_e   kind_nxt;
   logic [7:0]  code_nxt;

   // address decode, shared by read and write paths
   function automatic logic [2:0] reg_index(input logic [15:0] a);
      case (a)
         ADDR_TEMP_UNIT:  reg_index = 3'h0;
         ADDR_DEC_POINT:  reg_index = 3'h1;
         ADDR_MAINS_FREQ: reg_index = 3'h2;
         ADDR_LANGUAGE:   reg_index = 3'h3;
         ADDR_RATIO2_EN:  reg_index = 3'h4;
         default:         reg_index = REG_NONE;
      endcase
   endfunction : reg_index

   assign sel_idx  = reg_index(qry_reg_addr);
   assign is_write = (qry_func == FC_WRITE_SINGLE) || (qry_func == FC_WRITE_MULTI);

   // priority: comm error, function, busy, state, nak, file size, address, value
   always_comb
   begin
      kind_nxt = MBXR_RSP_NORMAL;
      code_nxt = 8'h00;
      if (qry_comm_err)
         kind_nxt = MBXR_RSP_NONE;
      else if (qry_func[7] || !(qry_func == FC_READ_HOLD || qry_func == FC_READ_INPUT
               || is_write || qry_func == FC_READ_FILE))
      begin
         kind_nxt = MBXR_RSP_EXC;
         code_nxt = EXC_ILL_FUNC;
      end
      else if (dev_busy)
      begin
         kind_nxt = MBXR_RSP_EXC;
         code_nxt = EXC_BUSY;
      end
      else if (dev_fault)
      begin
         kind_nxt = MBXR_RSP_EXC;
         code_nxt = EXC_DEV_FAIL;
      end
      else if (dev_nak)
      begin
         kind_nxt = MBXR_RSP_EXC;
         code_nxt = EXC_NAK;
      end
      else if (qry_func == FC_READ_FILE)
      begin
         if (qry_file_words > MAX_FILE_WORDS)
         begin
            kind_nxt = MBXR_RSP_EXC;
            code_nxt = EXC_BUF_OVF;
         end
      end
      else if (sel_idx == REG_NONE)
      begin
         kind_nxt = MBXR_RSP_EXC;
         code_nxt = EXC_ILL_ADDR;
      end
      else if (is_write && !val_ok)
      begin
         kind_nxt = MBXR_RSP_EXC;
         code_nxt = EXC_ILL_VALUE;
      end
      else if (!is_write && qry_value[7:0] > MAX_READ_COUNT)
      begin
         // a read count is range-checked against the bank size
         kind_nxt = MBXR_RSP_EXC;
         code_nxt = EXC_ILL_VALUE;
      end
   end

   // writes land only when the query is answered normally
   assign wr_en = qry_valid && is_write && (kind_nxt == MBXR_RSP_NORMAL);

   mbxr_reg_bank u_bank
   (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .sel_idx    (sel_idx),
      .wr_en      (wr_en),
      .wr_data    (qry_value),
      .rd_data    (rd_data),
      .val_ok     (val_ok),
      .temp_unit  (temp_unit),
      .dec_point  (dec_point),
      .mains_freq (mains_freq),
      .language   (language),
      .ratio2_en  (ratio2_en)
   );

   // response strobe and drop flag, one cycle after the query
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rsp_valid_r <= 1'b0;
         drop_r      <= 1'b0;
      end
      else
      begin
         rsp_valid_r <= qry_valid && (kind_nxt != MBXR_RSP_NONE);
         drop_r      <= qry_valid && (kind_nxt == MBXR_RSP_NONE);
      end
   end

   // response fields held until the next answered query; a dropped query leaves them
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rsp_exc_r  <= 1'b0;
         rsp_addr_r <= 8'h00;
         rsp_func_r <= 8'h00;
         rsp_code_r <= 8'h00;
         rsp_data_r <= 16'h0000;
      end
      else if (qry_valid && kind_nxt != MBXR_RSP_NONE)
      begin
         rsp_addr_r <= qry_slave_addr;
         if (kind_nxt == MBXR_RSP_EXC)
         begin
            rsp_exc_r  <= 1'b1;
            rsp_func_r <= qry_func | FC_EXC_FLAG;
            rsp_code_r <= code_nxt;
            rsp_data_r <= 16'h0000;
         end
         else
         begin
            rsp_exc_r  <= 1'b0;
            rsp_func_r <= qry_func;
            rsp_code_r <= 8'h00;
            rsp_data_r <= is_write ? qry_value : rd_data;
         end
      end
   end

   assign rsp_valid      = rsp_valid_r;
   assign rsp_exception  = rsp_exc_r;
   assign rsp_slave_addr = rsp_addr_r;
   assign rsp_func       = rsp_func_r;
   assign rsp_exc_code   = rsp_code_r;
   assign rsp_data       = rsp_data_r;
   assign rsp_dropped    = drop_r;
endmodule : mbxr_responder
`default_nettype wire

// [tb/mbxr_responder_assertions.sv]
// checker on the responder ports
`timescale 1ns/100ps
`default_nettype none
module mbxr_responder_assertions
   import mbxr_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   // query side
   input wire logic        qry_valid,
   input wire logic        qry_comm_err,
   input wire logic [7:0]  qry_func,
   input wire logic        dev_busy,
   // response side
   input wire logic        rsp_valid,
   input wire logic        rsp_exception,
   input wire logic [7:0]  rsp_func,
   input wire logic [7:0]  rsp_exc_code,
   input wire logic        rsp_dropped,
   input wire logic [15:0] dec_point
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic fc_ok;
   assign fc_ok = qry_func inside {FC_READ_HOLD, FC_READ_INPUT, FC_WRITE_SINGLE,
                                   FC_WRITE_MULTI, FC_READ_FILE};
   sequence s_good; qry_valid && !qry_comm_err; endsequence
   sequence s_exc; rsp_valid && rsp_exception; endsequence
   a_drop_bad:
      assert property (qry_valid && qry_comm_err |=> rsp_dropped && !rsp_valid)
      else $error("corrupt query answered");
   a_answer_good:
      assert property (s_good |=> rsp_valid && !rsp_dropped) else $error("query not answered");
   a_normal_echo:
      assert property (s_good ##1 !rsp_exception |-> rsp_func == $past(qry_func))
      else $error("function not echoed");
   a_exc_flag:
      assert property (s_good ##1 s_exc |-> rsp_func == ($past(qry_func) | FC_EXC_FLAG))
      else $error("exception flag missing");
   a_exc_code:
      assert property (s_exc |-> rsp_exc_code inside {[8'h01:8'h04], 8'h06, 8'h07, 8'h09})
      else $error("bad exception code");
   a_ill_func:
      assert property (qry_valid && !qry_comm_err && !fc_ok |=> rsp_exc_code == EXC_ILL_FUNC)
      else $error("illegal function code wrong");
   a_busy_code:
      assert property (qry_valid && !qry_comm_err && fc_ok && dev_busy
                       |=> rsp_exc_code == EXC_BUSY)
      else $error("busy code wrong");
   a_dp_range:
      assert property (dec_point <= MAX_DEC_POINT) else $error("decimal point out of range");
endmodule : mbxr_responder_assertions
bind mbxr_responder mbxr_responder_assertions u_chk (.ref_clk, .sys_rst, .qry_valid,
   .qry_comm_err, .qry_func, .dev_busy, .rsp_valid, .rsp_exception, .rsp_func,
   .rsp_exc_code, .rsp_dropped, .dec_point);
`default_nettype wire

// [tb/mbxr_master_model.sv]
// modbus master model: sends queries, flags a missing reply
`timescale 1ns/100ps
`default_nettype none
module mbxr_master_model
(
   // clock and reply
   input wire logic    ref_clk,
   input wire logic    rsp_valid,
   // query
   output logic        qry_valid,
   output logic        qry_comm_err,
   output logic [7:0]  qry_slave_addr,
   output logic [7:0]  qry_func,
   output logic [15:0] qry_reg_addr,
   output logic [15:0] qry_value,
   output logic [7:0]  qry_file_words,
   // no reply seen
   output logic        timed_out
);
   initial
   begin
      {qry_valid, qry_comm_err, timed_out} = 3'b000;
      {qry_slave_addr, qry_func, qry_reg_addr, qry_value, qry_file_words} = {8'h02, 48'h0};
   end
   // corrupt only when a scenario asks for it
   task automatic ask(input logic [7:0] f, input logic [15:0] a, v, input logic [7:0] w,
                      input logic bad);
      @(negedge ref_clk);
      qry_valid = 1'b1;
      {qry_comm_err, qry_func, qry_reg_addr, qry_value, qry_file_words} = {bad, f, a, v, w};
      @(negedge ref_clk);
      qry_valid = 1'b0;
      // junk after release so nothing leans on stale fields
      {qry_comm_err, qry_func, qry_reg_addr, qry_value, qry_file_words} = ~{bad, f, a, v, w};
      // reply pulse stands only until the next rising edge, so look now
      timed_out = !rsp_valid;
   endtask : ask
endmodule : mbxr_master_model
`default_nettype wire

// [tb/tb_mbxr_responder.sv]
// self-checking bench for the modbus responder
`timescale 1ns/100ps
`default_nettype none
module tb_mbxr_responder
   import mbxr_pkg::*;
   ;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [2:0]  dev = 3'b000;
   logic        qry_valid, qry_comm_err, timed_out, rsp_valid, rsp_exception, rsp_dropped;
   logic [7:0]  qry_slave_addr, qry_func, qry_file_words;
   logic [7:0]  rsp_slave_addr, rsp_func, rsp_exc_code;
   logic [15:0] qry_reg_addr, qry_value, rsp_data;
   wire logic [79:0] views;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   logic [15:0] adr [5] = '{ADDR_TEMP_UNIT, ADDR_DEC_POINT, ADDR_MAINS_FREQ, ADDR_LANGUAGE,
                            ADDR_RATIO2_EN};
   logic [15:0] mx [5]  = '{MAX_TEMP_UNIT, MAX_DEC_POINT, MAX_MAINS_FREQ, MAX_LANGUAGE,
                            MAX_RATIO2_EN};

   mbxr_responder DUT (.ref_clk, .sys_rst, .qry_valid, .qry_comm_err, .qry_slave_addr,
      .qry_func, .qry_reg_addr, .qry_value, .qry_file_words, .dev_busy(dev[2]),
      .dev_fault(dev[1]), .dev_nak(dev[0]), .rsp_valid, .rsp_exception, .rsp_slave_addr,
      .rsp_func, .rsp_exc_code, .rsp_data, .rsp_dropped, .temp_unit(views[79:64]),
      .dec_point(views[63:48]), .mains_freq(views[47:32]), .language(views[31:16]),
      .ratio2_en(views[15:0]));
   mbxr_master_model u_master (.ref_clk, .rsp_valid, .qry_valid, .qry_comm_err,
      .qry_slave_addr, .qry_func, .qry_reg_addr, .qry_value, .qry_file_words, .timed_out);

   task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic finish_test;
      if (mismatches == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test

   task automatic xc(input logic [7:0] f, input logic [15:0] a, v, input logic [7:0] w, c);
      u_master.ask(f, a, v, w, 1'b0);
      chk({timed_out, rsp_valid, rsp_exception}, 3'b011);
      chk({rsp_func, rsp_exc_code}, {f | 8'h80, c});
      chk(rsp_slave_addr, 8'h02);
   endtask : xc

   task automatic t_regs;
      for (int i = 0; i < 5; i++)
      begin
         u_master.ask(FC_WRITE_SINGLE, adr[i], mx[i], 8'h00, 1'b0);
         chk({rsp_valid, rsp_exception, rsp_func}, {2'b10, FC_WRITE_SINGLE});
         xc(FC_WRITE_SINGLE, adr[i], mx[i] + 16'h1, 8'h00, EXC_ILL_VALUE);
         u_master.ask(FC_READ_HOLD, adr[i], 16'h1, 8'h00, 1'b0);
         chk({rsp_func, rsp_data, views[79 - 16*i -: 16]}, {FC_READ_HOLD, mx[i], mx[i]});
      end
   endtask : t_regs

   task automatic t_codes;
      logic [7:0] dc [3] = '{EXC_BUSY, EXC_DEV_FAIL, EXC_NAK};
      xc(8'h05, ADDR_DEC_POINT, 16'h1, 8'h00, EXC_ILL_FUNC);
      xc(8'h83, ADDR_DEC_POINT, 16'h1, 8'h00, EXC_ILL_FUNC);
      xc(FC_READ_HOLD, 16'h1820, 16'h2, 8'h00, EXC_ILL_ADDR);
      xc(FC_READ_INPUT, ADDR_LANGUAGE, 16'h6, 8'h00, EXC_ILL_VALUE);
      xc(FC_READ_FILE, 16'h0, 16'h0, 8'h7E, EXC_BUF_OVF);
      u_master.ask(FC_READ_FILE, 16'h0, 16'h0, 8'h7D, 1'b0);
      chk({rsp_valid, rsp_exception, rsp_func}, {2'b10, FC_READ_FILE});
      // overlapping states check the priority too
      for (int i = 0; i < 3; i++)
      begin
         dev = 3'(3'b111 >> i);
         xc(FC_WRITE_MULTI, ADDR_DEC_POINT, 16'h1, 8'h00, dc[i]);
      end
      dev = 3'b000;
      // master writes 2 to the decimal point once the device is free
      u_master.ask(FC_WRITE_MULTI, ADDR_DEC_POINT, 16'h2, 8'h00, 1'b0);
      chk({rsp_valid, rsp_exception, rsp_func}, {2'b10, FC_WRITE_MULTI});
      chk({rsp_data, views[63:48]}, {16'h0002, 16'h0002});
   endtask : t_codes

   task automatic t_corrupt;
      u_master.ask(FC_WRITE_SINGLE, ADDR_DEC_POINT, 16'h1, 8'h00, 1'b1);
      chk({timed_out, rsp_dropped, rsp_valid}, 3'b110);
      chk({rsp_func, views[63:48]}, {FC_WRITE_MULTI, 16'h0002});
   endtask : t_corrupt

   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         mismatches++;
         finish_test;
      end
   end

   initial
   begin
      repeat (4) @(negedge ref_clk);
      sys_rst = 1'b0;
      chk(views, {RST_TEMP_UNIT, RST_DEC_POINT, RST_MAINS_FREQ, RST_LANGUAGE, RST_RATIO2_EN});
      t_regs;
      t_codes;
      t_corrupt;
      finish_test;
   end
endmodule : tb_mbxr_responder
`default_nettype wire
